// >>> hup_fifo_mem.sv
// Byte store for one FIFO: one write port, one registered read port.
`include "hup_map.svh"
module hup_fifo_mem
(
    input  wire logic   i_core_clk,
    hup_mem_if.store    m
);
    logic [7:0] mem_r [0:`HUP_FIFO_DEPTH-1];
    logic [7:0] rdata_r;

    // A read of the address written on the same edge returns the old byte.
    always_ff @(posedge i_core_clk)
    begin
        if (m.en)
        begin
            if (m.we)
            begin
                mem_r[m.waddr] <= m.wdata;
            end
            rdata_r <= mem_r[m.raddr];
        end
    end

    assign m.rdata = rdata_r;
endmodule

// >>> hup_host_model.sv
// Behavioural host controller on the far side of the serial link.
module hup_host_model
(
    input  wire logic i_core_clk,
    input  wire logic i_dev_tx,
    input  wire logic i_dev_rts_n,
    output logic      o_dev_rx,
    output logic      o_dev_cts_n
);
    timeunit 1ns;
    timeprecision 1ps;
    int         bit_cycles = 63;
    logic [7:0] rx_q [$];
    logic [7:0] b;
    initial
    begin
        o_dev_rx = 1'b1;
        o_dev_cts_n = 1'b1;
    end
    // Called between characters, and once in mid stop bit, after the host has taken a byte.
    task automatic set_permit(input logic v);
        @(posedge i_core_clk);
        o_dev_cts_n <= v;
    endtask
    // A trailing idle bit gives the receiver time to settle before the next start.
    task automatic send(input logic [7:0] d);
        logic [10:0] f;
        f = {2'b11, d, 1'b0};
        while (i_dev_rts_n !== 1'b0)
            @(posedge i_core_clk);
        for (int i = 0; i < 11; i++)
        begin
            @(posedge i_core_clk);
            o_dev_rx <= f[i];
            repeat (bit_cycles - 1) @(posedge i_core_clk);
        end
    endtask
    always
    begin
        @(negedge i_dev_tx);
        repeat (bit_cycles / 2) @(posedge i_core_clk);
        for (int i = 0; i < 8; i++)
        begin
            repeat (bit_cycles) @(posedge i_core_clk);
            b[i] = i_dev_tx;
        end
        repeat (bit_cycles) @(posedge i_core_clk);
        if (i_dev_tx === 1'b1)
            rx_q.push_back(b);
    end
endmodule

// >>> hup_map.svh
// Named constants for the radio-section serial link: rates, depths, offsets and fields.
// Functional notes
// - Four wires: serial in, out, request, permit.
// - Bit rate programmable from 9600 to 4M.
// - Auto-detect rate, adopt and report it.
// - Host rate change rewrites baud register.
// - 1040-byte receive and transmit FIFOs.
// - FIFOs reachable from the system bus.
// - Carries H4, extended H4 or H5.
// - Default rate is 115.2 kbaud.
// - H5 leaves request and permit unused.
// - Rate comes from config record or detection.
// - Combined rate error within two percent.
// - Flow lines active low, low means go.
// - Transmit within 1.5 bits of permit low.
// - Request high within half bit after stop.
// - Radio enable low holds section in reset.
// - Regulators on when either enable high.
// - Internal reset releases within 110 ms.
`ifndef HUP_MAP_SVH
`define HUP_MAP_SVH

`define HUP_CLK_HZ          250000000
`define HUP_DEF_BAUD        115200
`define HUP_MIN_BAUD        9600
`define HUP_MAX_BAUD        4000000
`define HUP_DIV_DEF         (`HUP_CLK_HZ / `HUP_DEF_BAUD)
`define HUP_DIV_MAX         (`HUP_CLK_HZ / `HUP_MIN_BAUD)
`define HUP_DIV_MIN         ((`HUP_CLK_HZ + `HUP_MAX_BAUD - 1) / `HUP_MAX_BAUD)
`define HUP_POR_MAX_MS      110
`define HUP_POR_CYCLES      (`HUP_POR_MAX_MS * (`HUP_CLK_HZ / 1000))
`define HUP_POR_W           25
`define HUP_FIFO_DEPTH      1040
`define HUP_PTR_W           11
`define HUP_RTS_MARGIN      16
`define HUP_REG_CTRL        4'h0
`define HUP_REG_BAUD        4'h4
`define HUP_REG_STATUS      4'h8
`define HUP_REG_DATA        4'hC
`define HUP_CTRL_MODE_LSB   0
`define HUP_CTRL_ABAUD_BIT  2
`define HUP_STAT_RXLVL_LSB  0
`define HUP_STAT_TXLVL_LSB  16
`define HUP_STAT_ABDONE_BIT 27
`define HUP_STAT_RXOVR_BIT  28
`define HUP_STAT_FERR_BIT   29
`define HUP_STAT_TXOVF_BIT  30
`define HUP_STAT_PERMIT_BIT 31
`define HUP_DATA_VALID_BIT  8

`endif

// >>> hup_mem_if.sv
// Carrier between the link logic and one byte store.
`include "hup_map.svh"
interface hup_mem_if;
    logic                  en;
    logic                  we;
    logic [`HUP_PTR_W-1:0] waddr;
    logic [`HUP_PTR_W-1:0] raddr;
    logic [7:0]            wdata;
    logic [7:0]            rdata;

    modport store (input en, input we, input waddr, input raddr, input wdata, output rdata);
    modport user  (output en, output we, output waddr, output raddr, output wdata, input rdata);
endinterface

// >>> hup_pkg.sv
// Types shared by the serial link modules.
`include "hup_map.svh"
package hup_pkg;

    typedef enum logic [1:0]
    {
        HUP_H4  = 2'b00,
        HUP_EH4 = 2'b01,
        HUP_H5  = 2'b10
    } hup_frame_t;

    typedef enum logic [2:0]
    {
        HUP_RX_IDLE  = 3'b000,
        HUP_RX_START = 3'b001,
        HUP_RX_DATA  = 3'b010,
        HUP_RX_STOP  = 3'b011,
        HUP_RX_ABAUD = 3'b100
    } hup_rx_t;

    typedef enum logic [2:0]
    {
        HUP_TX_IDLE  = 3'b000,
        HUP_TX_FETCH = 3'b001,
        HUP_TX_START = 3'b010,
        HUP_TX_DATA  = 3'b011,
        HUP_TX_STOP  = 3'b100
    } hup_tx_t;

    typedef struct packed
    {
        logic                   rxd_s1;
        logic                   rxd_s2;
        logic                   rx_prev;
        logic                   cts_s1;
        logic                   cts_s2;
        logic                   rad_s1;
        logic                   rad_s2;
        logic                   wl_s1;
        logic                   wl_s2;
        logic [`HUP_POR_W-1:0]  por_cnt;
        logic                   por_done;
        logic                   buck;
        logic                   in_rst;
        hup_frame_t             mode;
        logic                   ab_arm;
        logic                   ab_done;
        logic [15:0]            div;
        logic                   rx_ovr;
        logic                   rx_ferr;
        logic                   tx_ovf;
        hup_rx_t                rx_st;
        logic [15:0]            rx_cnt;
        logic [2:0]             rx_bit;
        logic [7:0]             rx_sh;
        logic [`HUP_PTR_W-1:0]  rx_wp;
        logic [`HUP_PTR_W-1:0]  rx_rp;
        logic [`HUP_PTR_W-1:0]  rx_lvl;
        hup_tx_t                tx_st;
        logic [15:0]            tx_cnt;
        logic [2:0]             tx_bit;
        logic [7:0]             tx_sh;
        logic [`HUP_PTR_W-1:0]  tx_wp;
        logic [`HUP_PTR_W-1:0]  tx_rp;
        logic [`HUP_PTR_W-1:0]  tx_lvl;
        logic                   txd;
        logic                   rts_n;
        logic [1:0]             rd_stage;
        logic                   rd_valid;
        logic [31:0]            rdata;
    } hup_state_t;

endpackage

// >>> hup_uart.sv
// Radio-section host serial link with power gating, Avalon-MM register slave.
//
// The implementer's own choices: the placing of the registers and register access over Avalon-MM.
`include "hup_map.svh"
module hup_uart
    import hup_pkg::*;
#(
    parameter int unsigned POR_CYCLES = `HUP_POR_CYCLES
)
(
    input  wire logic        i_core_clk,
    input  wire logic        i_reset,
    input  wire logic        i_clk_en,
    input  wire logic [3:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic      [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest,
    input  wire logic        i_serial_in_line,
    output logic             o_serial_out_line,
    output logic             o_flow_request_out_n,
    input  wire logic        i_flow_permit_in_n,
    input  wire logic        i_radio_section_power_enable,
    input  wire logic        i_wlan_power_enable,
    output logic             o_core_buck_regulator_enable,
    output logic             o_radio_section_in_reset
);
    localparam logic [`HUP_PTR_W-1:0] DEPTH = `HUP_PTR_W'(`HUP_FIFO_DEPTH);
    localparam logic [`HUP_PTR_W-1:0] LAST  = `HUP_PTR_W'(`HUP_FIFO_DEPTH - 1);
    localparam logic [`HUP_PTR_W-1:0] ONE   = `HUP_PTR_W'(1);
    localparam logic [`HUP_PTR_W-1:0] RTS_M = `HUP_PTR_W'(`HUP_RTS_MARGIN);

    hup_state_t s_r;
    hup_state_t s_nxt;
    logic       sec_rst;
    logic       tx_push;
    logic       tx_pop;
    logic       rx_push;
    logic       rx_pop;
    logic       set_ovr;
    logic       set_ferr;
    logic       set_tovf;
    logic       clr_ovr;
    logic       clr_ferr;
    logic       clr_tovf;
    logic [31:0] rmux;

    hup_mem_if tx_m ();
    hup_mem_if rx_m ();

    function automatic logic [`HUP_PTR_W-1:0] ptr_inc(input logic [`HUP_PTR_W-1:0] p);
        ptr_inc = (p == LAST) ? '0 : p + ONE;
    endfunction

    // Out-of-range divisors are pulled back into the supported rate span.
    function automatic logic [15:0] div_clamp(input logic [16:0] v);
        if (v > 17'(`HUP_DIV_MAX))
            div_clamp = 16'(`HUP_DIV_MAX);
        else if (v < 17'(`HUP_DIV_MIN))
            div_clamp = 16'(`HUP_DIV_MIN);
        else
            div_clamp = v[15:0];
    endfunction

    function automatic hup_frame_t frame_decode(input logic [1:0] code);
        unique case (code)
            2'b00:   frame_decode = HUP_H4;
            2'b01:   frame_decode = HUP_EH4;
            2'b10:   frame_decode = HUP_H5;
            default: frame_decode = HUP_H4;
        endcase
    endfunction

    function automatic hup_state_t hup_rst_state();
        hup_state_t r;
        r         = '0;
        r.rxd_s1  = 1'b1;
        r.rxd_s2  = 1'b1;
        r.rx_prev = 1'b1;
        r.cts_s1  = 1'b1;
        r.cts_s2  = 1'b1;
        r.in_rst  = 1'b1;
        r.mode    = HUP_H4;
        r.div     = 16'(`HUP_DIV_DEF);
        r.rx_st   = HUP_RX_IDLE;
        r.tx_st   = HUP_TX_IDLE;
        r.txd     = 1'b1;
        r.rts_n   = 1'b1;
        hup_rst_state = r;
    endfunction

    // Section reset clears the link but keeps pin sampling, the power timer and the bus answer.
    function automatic hup_state_t hup_sec_reset(input hup_state_t v);
        hup_state_t r;
        r          = hup_rst_state();
        r.rxd_s1   = v.rxd_s1;
        r.rxd_s2   = v.rxd_s2;
        r.rx_prev  = v.rx_prev;
        r.cts_s1   = v.cts_s1;
        r.cts_s2   = v.cts_s2;
        r.rad_s1   = v.rad_s1;
        r.rad_s2   = v.rad_s2;
        r.wl_s1    = v.wl_s1;
        r.wl_s2    = v.wl_s2;
        r.por_cnt  = v.por_cnt;
        r.por_done = v.por_done;
        r.buck     = v.buck;
        r.rd_stage = v.rd_stage;
        r.rd_valid = 1'b0;
        r.rdata    = v.rdata;
        hup_sec_reset = r;
    endfunction

    always_comb
    begin
        s_nxt    = s_r;
        tx_push  = 1'b0;
        tx_pop   = 1'b0;
        rx_push  = 1'b0;
        rx_pop   = 1'b0;
        set_ovr  = 1'b0;
        set_ferr = 1'b0;
        set_tovf = 1'b0;
        clr_ovr  = 1'b0;
        clr_ferr = 1'b0;
        clr_tovf = 1'b0;
        rmux     = '0;
        sec_rst  = ~s_r.por_done | ~s_r.rad_s2;

        s_nxt.rxd_s1  = i_serial_in_line;
        s_nxt.rxd_s2  = s_r.rxd_s1;
        s_nxt.rx_prev = s_r.rxd_s2;
        s_nxt.cts_s1  = i_flow_permit_in_n;
        s_nxt.cts_s2  = s_r.cts_s1;
        s_nxt.rad_s1  = i_radio_section_power_enable;
        s_nxt.rad_s2  = s_r.rad_s1;
        s_nxt.wl_s1   = i_wlan_power_enable;
        s_nxt.wl_s2   = s_r.wl_s1;
        s_nxt.buck    = s_r.rad_s2 | s_r.wl_s2;

        if (!s_r.por_done)
        begin
            if (s_r.por_cnt >= `HUP_POR_W'(POR_CYCLES - 1))
                s_nxt.por_done = 1'b1;
            else
                s_nxt.por_cnt = s_r.por_cnt + `HUP_POR_W'(1);
        end

        // Register writes take effect on the request cycle; writes never wait.
        if (i_avs_write && !sec_rst)
        begin
            case (i_avs_address)
                `HUP_REG_CTRL:
                begin
                    if (i_avs_byteenable[0])
                    begin
                        s_nxt.mode   = frame_decode(i_avs_writedata[`HUP_CTRL_MODE_LSB +: 2]);
                        s_nxt.ab_arm = i_avs_writedata[`HUP_CTRL_ABAUD_BIT];
                    end
                end
                `HUP_REG_BAUD:
                begin
                    s_nxt.div = div_clamp({1'b0,
                        i_avs_byteenable[1] ? i_avs_writedata[15:8] : s_r.div[15:8],
                        i_avs_byteenable[0] ? i_avs_writedata[7:0] : s_r.div[7:0]});
                    s_nxt.ab_done = 1'b0;
                end
                `HUP_REG_STATUS:
                begin
                    clr_ovr  = i_avs_byteenable[3] & i_avs_writedata[`HUP_STAT_RXOVR_BIT];
                    clr_ferr = i_avs_byteenable[3] & i_avs_writedata[`HUP_STAT_FERR_BIT];
                    clr_tovf = i_avs_byteenable[3] & i_avs_writedata[`HUP_STAT_TXOVF_BIT];
                end
                `HUP_REG_DATA:
                begin
                    if (i_avs_byteenable[0])
                    begin
                        if (s_r.tx_lvl != DEPTH)
                            tx_push = 1'b1;
                        else
                            set_tovf = 1'b1;
                    end
                end
                default: ;
            endcase
        end

        case (i_avs_address)
            `HUP_REG_CTRL:   rmux = {29'h0, s_r.ab_arm, s_r.mode};
            `HUP_REG_BAUD:   rmux = {16'h0, s_r.div};
            `HUP_REG_STATUS: rmux = {~s_r.cts_s2, s_r.tx_ovf, s_r.rx_ferr, s_r.rx_ovr,
                                     s_r.ab_done, s_r.tx_lvl, 5'h0, s_r.rx_lvl};
            `HUP_REG_DATA:   rmux = {23'h0, s_r.rd_valid, rx_m.rdata};
            default:         rmux = '0;
        endcase

        // Reads: stage 1 samples emptiness, stage 2 captures data and pops, stage 3 answers.
        unique case (s_r.rd_stage)
            2'b00:
            begin
                if (i_avs_read)
                begin
                    s_nxt.rd_valid = (i_avs_address == `HUP_REG_DATA) && (s_r.rx_lvl != '0);
                    s_nxt.rd_stage = 2'b01;
                end
            end
            2'b01:
            begin
                s_nxt.rdata    = sec_rst ? '0 : rmux;
                rx_pop         = s_r.rd_valid & ~sec_rst;
                s_nxt.rd_stage = 2'b10;
            end
            2'b10:   s_nxt.rd_stage = 2'b00;
            default: s_nxt.rd_stage = 2'b00;
        endcase

        unique case (s_r.tx_st)
            HUP_TX_IDLE:
            begin
                if ((s_r.tx_lvl != '0) && ((s_r.mode == HUP_H5) || !s_r.cts_s2))
                    s_nxt.tx_st = HUP_TX_FETCH;
            end
            HUP_TX_FETCH:
            begin
                s_nxt.tx_sh  = tx_m.rdata;
                tx_pop       = 1'b1;
                s_nxt.txd    = 1'b0;
                s_nxt.tx_cnt = s_r.div - 16'h1;
                s_nxt.tx_st  = HUP_TX_START;
            end
            HUP_TX_START:
            begin
                if (s_r.tx_cnt != 16'h0)
                    s_nxt.tx_cnt = s_r.tx_cnt - 16'h1;
                else
                begin
                    s_nxt.txd    = s_r.tx_sh[0];
                    s_nxt.tx_bit = 3'h0;
                    s_nxt.tx_cnt = s_r.div - 16'h1;
                    s_nxt.tx_st  = HUP_TX_DATA;
                end
            end
            HUP_TX_DATA:
            begin
                if (s_r.tx_cnt != 16'h0)
                    s_nxt.tx_cnt = s_r.tx_cnt - 16'h1;
                else
                begin
                    s_nxt.tx_cnt = s_r.div - 16'h1;
                    if (s_r.tx_bit == 3'h7)
                    begin
                        s_nxt.txd   = 1'b1;
                        s_nxt.tx_st = HUP_TX_STOP;
                    end
                    else
                    begin
                        s_nxt.tx_sh  = {1'b0, s_r.tx_sh[7:1]};
                        s_nxt.txd    = s_r.tx_sh[1];
                        s_nxt.tx_bit = s_r.tx_bit + 3'h1;
                    end
                end
            end
            HUP_TX_STOP:
            begin
                if (s_r.tx_cnt != 16'h0)
                    s_nxt.tx_cnt = s_r.tx_cnt - 16'h1;
                else
                    s_nxt.tx_st = HUP_TX_IDLE;
            end
            default: s_nxt.tx_st = HUP_TX_IDLE;
        endcase

        unique case (s_r.rx_st)
            HUP_RX_IDLE:
            begin
                if (s_r.rx_prev && !s_r.rxd_s2)
                begin
                    if (s_r.ab_arm)
                    begin
                        s_nxt.rx_cnt = 16'h1;
                        s_nxt.rx_st  = HUP_RX_ABAUD;
                    end
                    else
                    begin
                        s_nxt.rx_cnt = {1'b0, s_r.div[15:1]} - 16'h1;
                        s_nxt.rx_st  = HUP_RX_START;
                    end
                end
            end
            HUP_RX_ABAUD:
            begin
                // The first character must begin with a one bit so that the low run is one bit.
                if (!s_r.rxd_s2)
                begin
                    if (s_r.rx_cnt != 16'hFFFF)
                        s_nxt.rx_cnt = s_r.rx_cnt + 16'h1;
                end
                else
                begin
                    s_nxt.div     = div_clamp({1'b0, s_r.rx_cnt});
                    s_nxt.ab_arm  = 1'b0;
                    s_nxt.ab_done = 1'b1;
                    s_nxt.rx_st   = HUP_RX_IDLE;
                end
            end
            HUP_RX_START:
            begin
                if (s_r.rx_cnt != 16'h0)
                    s_nxt.rx_cnt = s_r.rx_cnt - 16'h1;
                else if (!s_r.rxd_s2)
                begin
                    s_nxt.rx_cnt = s_r.div - 16'h1;
                    s_nxt.rx_bit = 3'h0;
                    s_nxt.rx_st  = HUP_RX_DATA;
                end
                else
                    s_nxt.rx_st = HUP_RX_IDLE;
            end
            HUP_RX_DATA:
            begin
                if (s_r.rx_cnt != 16'h0)
                    s_nxt.rx_cnt = s_r.rx_cnt - 16'h1;
                else
                begin
                    s_nxt.rx_sh  = {s_r.rxd_s2, s_r.rx_sh[7:1]};
                    s_nxt.rx_cnt = s_r.div - 16'h1;
                    s_nxt.rx_bit = s_r.rx_bit + 3'h1;
                    if (s_r.rx_bit == 3'h7)
                        s_nxt.rx_st = HUP_RX_STOP;
                end
            end
            HUP_RX_STOP:
            begin
                if (s_r.rx_cnt != 16'h0)
                    s_nxt.rx_cnt = s_r.rx_cnt - 16'h1;
                else
                begin
                    // Returning at mid-stop leaves half a bit to catch the next start edge.
                    if (!s_r.rxd_s2)
                        set_ferr = 1'b1;
                    else if (s_r.rx_lvl != DEPTH)
                        rx_push = 1'b1;
                    else
                        set_ovr = 1'b1;
                    s_nxt.rx_st = HUP_RX_IDLE;
                end
            end
            default: s_nxt.rx_st = HUP_RX_IDLE;
        endcase

        if (tx_push)
            s_nxt.tx_wp = ptr_inc(s_r.tx_wp);
        if (tx_pop)
            s_nxt.tx_rp = ptr_inc(s_r.tx_rp);
        if (tx_push != tx_pop)
            s_nxt.tx_lvl = tx_push ? s_r.tx_lvl + ONE : s_r.tx_lvl - ONE;
        if (rx_push)
            s_nxt.rx_wp = ptr_inc(s_r.rx_wp);
        if (rx_pop)
            s_nxt.rx_rp = ptr_inc(s_r.rx_rp);
        if (rx_push != rx_pop)
            s_nxt.rx_lvl = rx_push ? s_r.rx_lvl + ONE : s_r.rx_lvl - ONE;

        // Level is taken after the push, so the line rises on the stop-sample edge.
        s_nxt.rts_n = (s_nxt.mode != HUP_H5) && ((DEPTH - s_nxt.rx_lvl) < RTS_M);

        s_nxt.rx_ovr  = (s_r.rx_ovr & ~clr_ovr) | set_ovr;
        s_nxt.rx_ferr = (s_r.rx_ferr & ~clr_ferr) | set_ferr;
        s_nxt.tx_ovf  = (s_r.tx_ovf & ~clr_tovf) | set_tovf;

        if (sec_rst)
            s_nxt = hup_sec_reset(s_nxt);
        else
            s_nxt.in_rst = 1'b0;
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
            s_r <= hup_rst_state();
        else if (i_clk_en)
            s_r <= s_nxt;
    end

    assign tx_m.en    = i_clk_en;
    assign tx_m.we    = tx_push;
    assign tx_m.waddr = s_r.tx_wp;
    assign tx_m.wdata = i_avs_writedata[7:0];
    assign tx_m.raddr = s_r.tx_rp;
    assign rx_m.en    = i_clk_en;
    assign rx_m.we    = rx_push;
    assign rx_m.waddr = s_r.rx_wp;
    assign rx_m.wdata = s_r.rx_sh;
    assign rx_m.raddr = s_r.rx_rp;

    hup_fifo_mem u_tx_mem
    (
        .i_core_clk (i_core_clk),
        .m          (tx_m.store)
    );

    hup_fifo_mem u_rx_mem
    (
        .i_core_clk (i_core_clk),
        .m          (rx_m.store)
    );

    assign o_serial_out_line            = s_r.txd;
    assign o_flow_request_out_n         = s_r.rts_n;
    assign o_core_buck_regulator_enable = s_r.buck;
    assign o_radio_section_in_reset     = s_r.in_rst;
    assign o_avs_readdata               = s_r.rdata;
    assign o_avs_waitrequest            = i_avs_read && (s_r.rd_stage != 2'b10);
endmodule

// >>> hup_uart_properties.sv
// Port-timing checker for the serial link, bound to its top module.
module hup_uart_properties
#(
    parameter int unsigned POR_CYCLES = 20
)
(
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic i_clk_en,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic o_avs_waitrequest,
    input wire logic o_serial_out_line,
    input wire logic o_flow_request_out_n,
    input wire logic i_radio_section_power_enable,
    input wire logic i_wlan_power_enable,
    input wire logic o_core_buck_regulator_enable,
    input wire logic o_radio_section_in_reset
);
    logic any_en;
    logic rad_off;
    assign any_en = i_radio_section_power_enable || i_wlan_power_enable;
    // A frozen clock enable legitimately holds the old reset state, so it pauses this check.
    assign rad_off = !i_radio_section_power_enable && i_clk_en;
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_reset);
    a_write_no_wait: assert property (i_avs_write |-> !o_avs_waitrequest)
        else $error("write was stalled");
    a_read_two_waits: assert property ($rose(i_avs_read) |-> o_avs_waitrequest [*2]
        ##1 !o_avs_waitrequest) else $error("read answer not in third cycle");
    a_buck_on: assert property (any_en [*5] |-> o_core_buck_regulator_enable)
        else $error("regulator stayed off");
    a_buck_off: assert property (!any_en [*5] |-> !o_core_buck_regulator_enable)
        else $error("regulator stayed on");
    a_section_held: assert property (rad_off [*5] |-> o_radio_section_in_reset)
        else $error("section left running");
    a_held_quiet: assert property (o_radio_section_in_reset [*2] |->
        o_serial_out_line && o_flow_request_out_n) else $error("link active in reset");
    a_start_bit: assert property ($fell(o_serial_out_line) |-> !o_serial_out_line [*8])
        else $error("start bit too short");
    a_request_live: assert property (
        $fell(o_flow_request_out_n) |-> !o_radio_section_in_reset) else $error("early grant");
    c_tx_start: cover property ($fell(o_serial_out_line));
    c_held: cover property ($rose(o_radio_section_in_reset));
    c_read: cover property ($rose(i_avs_read) ##2 !o_avs_waitrequest);
endmodule
bind hup_uart hup_uart_properties #(.POR_CYCLES(POR_CYCLES)) u_props (.*);

// >>> tb_hci_uart_with_power_gating.sv
// Self-checking bench of the radio-section serial link.
module tb_hci_uart_with_power_gating;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed
    {
        logic [3:0]  a;
        logic [31:0] w;
        logic [31:0] e;
    } hup_row_t;
    localparam hup_row_t ROWS [6] = '{'{4'h0, 32'h1, 32'h1}, '{4'h0, 32'h2, 32'h2},
        '{4'h0, 32'h0, 32'h0}, '{4'h2, 32'hFFFF_FFFF, 32'h0},
        '{4'h4, 32'h0000_FFFF, 32'h0000_65B9}, '{4'h4, 32'h0000_000A, 32'h0000_003F}};
    logic        clk, rst, rd, wr, txd, rts_n, rxd, cts_n, rad, wl, buck, inrst, stall, en;
    logic [3:0]  addr, be;
    logic [31:0] wdata, rdata, q;
    int          errors, tests_run, cycles, n;
    hup_uart #(.POR_CYCLES(20)) u_dut
    (
        .i_core_clk(clk),
        .i_reset(rst),
        .i_clk_en(en),
        .i_avs_address(addr),
        .i_avs_read(rd),
        .i_avs_write(wr),
        .i_avs_writedata(wdata),
        .i_avs_byteenable(be),
        .o_avs_readdata(rdata),
        .o_avs_waitrequest(stall),
        .i_serial_in_line(rxd),
        .o_serial_out_line(txd),
        .o_flow_request_out_n(rts_n),
        .i_flow_permit_in_n(cts_n),
        .i_radio_section_power_enable(rad),
        .i_wlan_power_enable(wl),
        .o_core_buck_regulator_enable(buck),
        .o_radio_section_in_reset(inrst)
    );
    hup_host_model u_host
    (
        .i_core_clk(clk),
        .i_dev_tx(txd),
        .i_dev_rts_n(rts_n),
        .o_dev_rx(rxd),
        .o_dev_cts_n(cts_n)
    );
    task automatic report_and_stop();
        if (errors == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    // The request holds until the edge that samples waitrequest low; data is taken there.
    task automatic bus(input logic r, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        rd <= r;
        wr <= !r;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        while (stall !== 1'b0)
            @(posedge clk);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            errors++;
            report_and_stop();
        end
    end
    initial
    begin
        {rd, wr, addr, wdata, rst, rad, wl, en, be} = {38'h0, 3'h6, 1'h1, 4'hF};
        repeat (8) @(posedge clk);
        check({txd, rts_n, inrst}, 3'b111);
        rst <= 1'b0;
        while (inrst !== 1'b0)
            @(negedge clk);
        bus(1'b1, 4'h4, 32'h0);
        check(q, 32'h0000_087A);
        foreach (ROWS[i])
        begin
            bus(1'b0, ROWS[i].a, ROWS[i].w);
            bus(1'b1, ROWS[i].a, 32'h0);
            check(q, ROWS[i].e);
        end
        be <= 4'h1;
        bus(1'b0, 4'h4, 32'h0000_FF3F);
        be <= 4'hF;
        bus(1'b1, 4'h4, 32'h0);
        check(q, 32'h0000_003F);
        u_host.set_permit(1'b1);
        bus(1'b0, 4'hC, 32'h0000_00A5);
        n = 0;
        repeat (200)
        begin
            @(negedge clk);
            n += !txd;
        end
        check(n, 0);
        u_host.set_permit(1'b0);
        n = 0;
        for (n = 0; txd === 1'b1; n++)
            @(negedge clk);
        check(n <= 94, 1);
        while (u_host.rx_q.size() == 0)
            @(posedge clk);
        check(u_host.rx_q.pop_front(), 32'hA5);
        u_host.set_permit(1'b1);
        bus(1'b0, 4'h0, 32'h2);
        bus(1'b0, 4'hC, 32'h5A);
        check(rts_n, 0);
        while (u_host.rx_q.size() == 0)
            @(posedge clk);
        check(u_host.rx_q.pop_front(), 32'h5A);
        bus(1'b0, 4'h4, 32'h0000_01F4);
        bus(1'b0, 4'h0, 32'h4);
        // An all-ones byte leaves the start bit as the only low run, so no stray edge follows.
        u_host.send(8'hFF);
        bus(1'b1, 4'h4, 32'h0);
        check(q, 32'd63);
        u_host.send(8'h3C);
        bus(1'b1, 4'hC, 32'h0);
        check(q, 32'h0000_013C);
        wl <= 1'b1;
        rad <= 1'b0;
        repeat (8) @(posedge clk);
        check({inrst, buck}, 2'b11);
        wl <= 1'b0;
        repeat (8) @(posedge clk);
        check(buck, 0);
        // The off-time is far shorter than a real regulator needs; no discharge is modelled.
        rad <= 1'b1;
        repeat (8) @(posedge clk);
        check(buck, 1);
        en <= 1'b0;
        rad <= 1'b0;
        wl <= 1'b1;
        repeat (8) @(posedge clk);
        check(inrst, 0);
        en <= 1'b1;
        repeat (8) @(posedge clk);
        check({inrst, buck}, 2'h3);
        report_and_stop();
    end
endmodule
